// *** jump_stack_pkg.sv ***
// Shared constants for the jump and subroutine control block, plus its stack pointer stepper.
`timescale 1ns/10ps
`default_nettype none
package jump_stack_pkg;
  // Register numbers of the processor's special registers.
  localparam logic [2:0]  SP_IDX       = 3'h6;
  localparam logic [2:0]  PC_IDX       = 3'h7;
  // A stack word is two bytes wide.
  localparam logic [15:0] STACK_STEP   = 16'h0002;
  // Opcode patterns: unconditional_jump 0001DD, subroutine_call 004RDD, return 00020R.
  localparam logic [9:0]  JUMP_OP      = 10'h001;
  localparam logic [6:0]  CALL_OP      = 7'h04;
  localparam logic [12:0] RETURN_OP    = 13'h0010;
  // Destination mode fields.
  localparam logic [2:0]  MODE_REG     = 3'h0;
  localparam logic [2:0]  MODE_REG_DEF = 3'h1;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
endpackage : jump_stack_pkg

module stack_step
  import jump_stack_pkg::*;
(
  input  wire logic [15:0] sp_i,
  input  wire logic        pop_i,
  output logic      [15:0] sp_next_o
);
  // A pop moves the pointer up one word, a push moves it down one word.
  assign sp_next_o = pop_i ? sp_i + STACK_STEP : sp_i - STACK_STEP;
endmodule // stack_step
`default_nettype wire

// *** jump_subroutine_control.sv ***
// Execution control for the jump, subroutine call and subroutine return instructions.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Jump loads PC with destination, flags unchanged.
// - Jump in register mode raises illegal instruction.
// - Register deferred jump uses register's held address.
// - Odd instruction fetch address raises boundary trap.
// - Call: hold target, push link, link=PC, jump.
// - Call through PC pushes return address, jumps.
// - Return: PC from register, pop stack into register.
module jump_subroutine_control
  import jump_stack_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [15:0] dst_addr_i,
  input  wire logic [15:0] reg_val_i,
  input  wire logic [15:0] sp_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic             odd_trap_o,
  output logic             wr_en_o,
  output logic      [2:0]  wr_sel_o,
  output logic      [15:0] wr_data_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [15:0] mem_addr_o,
  output logic      [15:0] mem_wdata_o
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_PUSH_WAIT,
    S_LOAD_TARGET,
    S_POP_WAIT,
    S_SP_INC,
    S_FINISH
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [15:0] tmp;
    logic [15:0] sp;
    logic [15:0] pcv;
    logic [15:0] newpc;
    logic [2:0]  rsel;
    logic        busy;
    logic        done;
    logic        illegal;
    logic        odd_trap;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [15:0] wr_data;
    logic        mem_req;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
  } ctl_t;

  ctl_t        q;
  ctl_t        d;
  logic [15:0] sp_down;
  logic [15:0] sp_up;
  logic        is_jump;
  logic        is_call;
  logic        is_return;
  logic [2:0]  dst_mode;

  // One stepper per direction keeps the push and pop arithmetic in one place.
  // The push side works on the incoming pointer, because the push is issued in the take cycle.
  stack_step u_push (
    .sp_i      (sp_i),
    .pop_i     (1'b0),
    .sp_next_o (sp_down)
  );
  stack_step u_pop (
    .sp_i      (q.sp),
    .pop_i     (1'b1),
    .sp_next_o (sp_up)
  );

  // Opcode decode of the instruction presented with the start pulse.
  assign is_jump   = (instr_i[15:6] == JUMP_OP);
  assign is_call   = (instr_i[15:9] == CALL_OP);
  assign is_return = (instr_i[15:3] == RETURN_OP);
  assign dst_mode  = instr_i[5:3];

  // Next-state logic; condition codes are never touched, so the block has no port for them.
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.illegal  = 1'b0;
    d.odd_trap = 1'b0;
    d.wr_en    = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        // Starts arriving while busy are ignored; the caller waits for done.
        if (start_i) begin
          d.tmp  = dst_addr_i;
          d.sp   = sp_i;
          d.pcv  = pc_i;
          if (is_jump && dst_mode == MODE_REG) begin
            // A register cannot be a jump target, so nothing is written.
            d.illegal = 1'b1;
            d.done    = 1'b1;
          end else if (is_jump) begin
            // Register deferred arrives as the register's content on the address input.
            d.wr_en   = 1'b1;
            d.wr_sel  = PC_IDX;
            d.wr_data = dst_addr_i;
            d.newpc   = dst_addr_i;
            d.st      = S_FINISH;
          end else if (is_call) begin
            d.rsel      = instr_i[8:6];
            d.wr_en     = 1'b1;
            d.wr_sel    = SP_IDX;
            d.wr_data   = sp_down;
            d.sp        = sp_down;
            d.mem_req   = 1'b1;
            d.mem_we    = 1'b1;
            d.mem_addr  = sp_down;
            d.mem_wdata = reg_val_i;
            d.st        = S_PUSH_WAIT;
          end else if (is_return) begin
            d.rsel     = instr_i[2:0];
            d.wr_en    = 1'b1;
            d.wr_sel   = PC_IDX;
            d.wr_data  = reg_val_i;
            d.newpc    = reg_val_i;
            d.mem_req  = 1'b1;
            d.mem_we   = 1'b0;
            d.mem_addr = sp_i;
            d.st       = S_POP_WAIT;
          end else begin
            // Opcodes outside this block are acknowledged and otherwise left alone.
            d.done = 1'b1;
          end
        end
      end
      S_PUSH_WAIT: begin
        if (mem_ack_i) begin
          // Linkage takes the return address; when it is the PC the next write overrides it.
          d.mem_req = 1'b0;
          d.wr_en   = 1'b1;
          d.wr_sel  = q.rsel;
          d.wr_data = q.pcv;
          d.st      = S_LOAD_TARGET;
        end
      end
      S_LOAD_TARGET: begin
        d.wr_en   = 1'b1;
        d.wr_sel  = PC_IDX;
        d.wr_data = q.tmp;
        d.newpc   = q.tmp;
        d.st      = S_FINISH;
      end
      S_POP_WAIT: begin
        if (mem_ack_i) begin
          d.mem_req = 1'b0;
          d.wr_en   = 1'b1;
          d.wr_sel  = q.rsel;
          d.wr_data = mem_rdata_i;
          if (q.rsel == PC_IDX) begin
            d.newpc = mem_rdata_i;
          end
          d.st = S_SP_INC;
        end
      end
      S_SP_INC: begin
        d.wr_en   = 1'b1;
        d.wr_sel  = SP_IDX;
        d.wr_data = sp_up;
        d.st      = S_FINISH;
      end
      S_FINISH: begin
        // The next fetch uses the new PC, so an odd value traps before it is used.
        d.done     = 1'b1;
        d.odd_trap = q.newpc[0];
        d.st       = S_IDLE;
      end
    endcase
    d.busy = (d.st != S_IDLE);
  end

  // State register; every output is a field of it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{st: S_IDLE, tmp: WORD_ZERO, sp: WORD_ZERO, pcv: WORD_ZERO,
             newpc: WORD_ZERO, rsel: PC_IDX, busy: 1'b0, done: 1'b0, illegal: 1'b0,
             odd_trap: 1'b0, wr_en: 1'b0, wr_sel: PC_IDX, wr_data: WORD_ZERO,
             mem_req: 1'b0, mem_we: 1'b0, mem_addr: WORD_ZERO, mem_wdata: WORD_ZERO};
    end else begin
      q <= d;
    end
  end

  assign busy_o      = q.busy;
  assign done_o      = q.done;
  assign illegal_o   = q.illegal;
  assign odd_trap_o  = q.odd_trap;
  assign wr_en_o     = q.wr_en;
  assign wr_sel_o    = q.wr_sel;
  assign wr_data_o   = q.wr_data;
  assign mem_req_o   = q.mem_req;
  assign mem_we_o    = q.mem_we;
  assign mem_addr_o  = q.mem_addr;
  assign mem_wdata_o = q.mem_wdata;

  // Checks that tie each step to the start pulse or memory answer that caused it.
  logic take;
  assign take = start_i && (q.st == S_IDLE);

  sequence pc_write_s(logic [15:0] v);
    wr_en_o && wr_sel_o == PC_IDX && wr_data_o == v;
  endsequence

  jump_target_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_jump && dst_mode != MODE_REG |=> pc_write_s($past(dst_addr_i)) ##1 done_o && !illegal_o)
    else $error("Jump did not load PC with destination.");

  jump_illegal_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_jump && dst_mode == MODE_REG |=> illegal_o && done_o && !wr_en_o)
    else $error("Register mode jump not flagged illegal.");

  deferred_legal_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_jump && dst_mode == MODE_REG_DEF |=> !illegal_o ##1 !illegal_o && done_o)
    else $error("Register deferred jump was refused.");

  odd_trap_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_jump && dst_mode != MODE_REG |=> ##1 odd_trap_o == $past(dst_addr_i[0], 2))
    else $error("Odd target trap mismatched.");

  sequence push_s;
    wr_en_o && wr_sel_o == SP_IDX && mem_req_o && mem_we_o && mem_addr_o == wr_data_o;
  endsequence

  call_push_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_call |=> push_s and (mem_wdata_o == $past(reg_val_i)) and (wr_data_o == $past(sp_i) - STACK_STEP))
    else $error("Call did not push linkage word below SP.");

  call_link_a: assert property (@(posedge clk_i) disable iff (reset_i)
    q.st == S_PUSH_WAIT && mem_ack_i |=> wr_en_o && wr_sel_o == q.rsel && wr_data_o == q.pcv
      ##1 pc_write_s(q.tmp) ##1 done_o)
    else $error("Call linkage or target load out of order.");

  return_pc_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take && is_return |=> pc_write_s($past(reg_val_i)) and (mem_req_o && !mem_we_o && mem_addr_o == $past(sp_i)))
    else $error("Return did not load PC then read stack.");

  pop_inc_a: assert property (@(posedge clk_i) disable iff (reset_i)
    q.st == S_POP_WAIT && mem_ack_i |=> wr_en_o && wr_data_o == $past(mem_rdata_i)
      ##1 wr_en_o && wr_sel_o == SP_IDX && wr_data_o == q.sp + STACK_STEP)
    else $error("Pop did not write register then SP plus two.");

endmodule // jump_subroutine_control
`default_nettype wire

// *** jump_subroutine_control_tb.sv ***
// Self-checking testbench for the jump and subroutine control block.
`timescale 1ns/10ps
`default_nettype none
module jump_subroutine_control_tb;
  logic        clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, slow = 1'b0;
  logic [15:0] instr_i = 16'h0000, dst_addr_i = 16'h0000, reg_val_i = 16'h0000;
  logic [15:0] sp_i = 16'h0000, pc_i = 16'h0000, mem_rdata_i, wr_data_o, mem_addr_o, mem_wdata_o;
  logic        mem_ack_i, busy_o, done_o, illegal_o, odd_trap_o, wr_en_o, mem_req_o, mem_we_o;
  logic [2:0]  wr_sel_o;
  logic [2:0]  ws [3];
  logic [15:0] wd [3];
  logic [15:0] nw, cyc;
  logic        ill, odd;
  logic [1:0]  bsy;
  int          failures = 0, tests_run = 0;
  // The memory model answers fast or slow as each scenario asks.
  stack_memory u_stack_memory (.clk_i(clk_i), .reset_i(reset_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .slow_i(slow), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  jump_subroutine_control u_jump_subroutine_control (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
    .instr_i(instr_i), .dst_addr_i(dst_addr_i), .reg_val_i(reg_val_i), .sp_i(sp_i), .pc_i(pc_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o), .odd_trap_o(odd_trap_o), .wr_en_o(wr_en_o), .wr_sel_o(wr_sel_o),
    .wr_data_o(wr_data_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int i, input logic [2:0] s, input logic [15:0] d);
    chk(16'(ws[i]), 16'(s));
    chk(wd[i], d);
  endtask
  task results;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Issues one instruction and logs register writes until done; the bound catches a hang.
  task automatic op(input logic [15:0] ins, dst, rv, sp, pc);
    logic fin;
    fin = 1'b0;
    nw  = 16'h0000;
    @(posedge clk_i);
    #1;
    {instr_i, dst_addr_i, reg_val_i, sp_i, pc_i} = {ins, dst, rv, sp, pc};
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    for (cyc = 16'h0000; cyc < 16'h0028 && !fin; cyc++) begin
      // Busy is logged in the first cycle after the take and again at done.
      if (cyc == 16'h0000) begin
        bsy[1] = busy_o;
      end
      if (wr_en_o === 1'b1 && nw < 16'h0003) begin
        ws[nw] = wr_sel_o;
        wd[nw] = wr_data_o;
        nw++;
      end
      if (done_o === 1'b1) begin
        ill = illegal_o;
        bsy[0] = busy_o;
        odd = odd_trap_o;
        fin = 1'b1;
        break;
      end
      @(posedge clk_i);
      #1;
    end
    if (!fin) begin
      failures++;
      results();
    end
  endtask
  task t_jump;
    op(16'h0057, 16'hfffe, 16'h0000, 16'h0100, 16'h0200);
    chk(cyc, 16'h0001);
    chk(nw, 16'h0001);
    wr(0, 3'h7, 16'hfffe);
    chk(16'({ill, odd}), 16'h0000);
    chk(16'(bsy), 16'h0002);
  endtask
  task t_mode0;
    op(16'h0043, 16'h3000, 16'h0000, 16'h0100, 16'h0200);
    chk(16'({nw[1:0], ill}), 16'h0001);
    chk(16'(bsy), 16'h0000);
    // An opcode outside the block only finishes: no write, no flag.
    op(16'h0000, 16'h3000, 16'h0000, 16'h0100, 16'h0200);
    chk(16'({nw[1:0], ill, odd}), 16'h0000);
  endtask
  task t_deferred_odd;
    op(16'h004b, 16'h2001, 16'h0000, 16'h0100, 16'h0200);
    wr(0, 3'h7, 16'h2001);
    chk(16'({ill, odd}), 16'h0001);
  endtask
  // Slow memory so the push waits; the stack word is checked in the model.
  task t_call;
    slow = 1'b1;
    op(16'h095f, 16'h4000, 16'h1234, 16'h0100, 16'h0204);
    chk(nw, 16'h0003);
    chk(16'(bsy), 16'h0002);
    wr(0, 3'h6, 16'h00fe);
    wr(1, 3'h5, 16'h0204);
    wr(2, 3'h7, 16'h4000);
    chk(u_stack_memory.last_addr, 16'h00fe);
    chk(u_stack_memory.last_wdata, 16'h1234);
    slow = 1'b0;
  endtask
  task t_call_pc;
    op(16'h09df, 16'h5001, 16'h0300, 16'h00fe, 16'h0300);
    wr(0, 3'h6, 16'h00fc);
    wr(1, 3'h7, 16'h0300);
    wr(2, 3'h7, 16'h5001);
    chk(u_stack_memory.last_wdata, 16'h0300);
    chk(16'(odd), 16'h0001);
  endtask
  // Two nested returns pop the words pushed by the calls, newest first.
  task t_returns;
    op(16'h0087, 16'h0000, 16'h6000, 16'h00fc, 16'h0000);
    wr(0, 3'h7, 16'h6000);
    wr(1, 3'h7, 16'h0300);
    wr(2, 3'h6, 16'h00fe);
    op(16'h0085, 16'h0000, 16'h2000, 16'h00fe, 16'h0000);
    wr(0, 3'h7, 16'h2000);
    wr(1, 3'h5, 16'h1234);
    wr(2, 3'h6, 16'h0100);
    chk(16'({u_stack_memory.last_we, odd}), 16'h0000);
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_jump();
    t_mode0();
    t_deferred_odd();
    t_call();
    t_call_pc();
    t_returns();
    results();
  end
endmodule // jump_subroutine_control_tb
`default_nettype wire

// *** stack_memory.sv ***
// Behavioural word memory that answers the block's stack accesses.
`timescale 1ns/10ps
`default_nettype none
module stack_memory (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        slow_i,
  output logic             ack_o,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem [16];
  logic [1:0]  wait_q;
  logic        served_q;
  logic [15:0] last_addr;
  logic [15:0] last_wdata;
  logic        last_we;
  // One answer per request; read data flips every idle cycle so no stale word looks valid.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o    <= 1'b0;
      wait_q   <= 2'h0;
      served_q <= 1'b0;
      rdata_o  <= 16'h0000;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!req_i) begin
        served_q <= 1'b0;
        wait_q   <= 2'h0;
      end else if (!served_q) begin
        if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
          ack_o      <= 1'b1;
          served_q   <= 1'b1;
          last_addr  <= addr_i;
          last_we    <= we_i;
          last_wdata <= wdata_i;
          if (we_i) begin
            mem[addr_i[4:1]] <= wdata_i;
          end else begin
            rdata_o <= mem[addr_i[4:1]];
          end
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule // stack_memory
`default_nettype wire
